// *** inc/stpmx_pkg.sv ***
// Package: constants and types for the shared serial/datamod pin mux
package stpmx_pkg;
  localparam int unsigned STPMX_CS_W       = 4;
  localparam int unsigned STPMX_LANE_W     = 4;
  localparam int unsigned STPMX_DATA_W     = 16;
  localparam int unsigned STPMX_DED_DATA_W = 2;
  localparam int unsigned STPMX_SHARED_W   = 14;
  // Datamod bit carried by each shared pin
  localparam int unsigned STPMX_BIT_CLK    = 4;
  localparam int unsigned STPMX_BIT_CS0    = 5;
  localparam int unsigned STPMX_BIT_CS1    = 6;
  localparam int unsigned STPMX_BIT_CS2    = 2;
  localparam int unsigned STPMX_BIT_CS3    = 3;
  localparam int unsigned STPMX_BIT_ENA    = 7;
  localparam int unsigned STPMX_BIT_MO0    = 8;
  localparam int unsigned STPMX_BIT_MI0    = 12;
  localparam logic        STPMX_RST_LEVEL  = 1'h0;
  typedef enum logic [1:0] {
    STPMX_OWN_NONE    = 2'h0,
    STPMX_OWN_PORT    = 2'h1,
    STPMX_OWN_DATAMOD = 2'h2
  } stpmx_owner_t;
endpackage

// *** inc/stpmx_sel_if.sv ***
// Interface: pin ownership select between top and select decoder
`timescale 1ns/100ps
`default_nettype none
interface stpmx_sel_if;
  import stpmx_pkg::*;
  logic         port_en;
  logic         datamod_en;
  stpmx_owner_t owner;
  modport dec (input port_en, input datamod_en, output owner);
  modport top (output port_en, output datamod_en, input owner);
endinterface
`default_nettype wire

// *** src/stpmx_sel.sv ***
// Module: ownership decoder from the two unit enables
`timescale 1ns/100ps
`default_nettype none
module stpmx_sel
  import stpmx_pkg::*;
(
  stpmx_sel_if.dec sel
);
  always_comb begin
    if (sel.port_en) begin
      sel.owner = STPMX_OWN_PORT;
    end else if (sel.datamod_en) begin
      sel.owner = STPMX_OWN_DATAMOD;
    end else begin
      sel.owner = STPMX_OWN_NONE;
    end
  end
endmodule
`default_nettype wire

// *** src/stpmx_pin_mux.sv ***
// Module: shared pin mux, serial port five versus data modification module
//
// Contract
// - Serial port enabled: it owns every shared pin
// - Datamod owns pins only when port disabled
// - Dedicated datamod pins and bits 1:0 pass always
// - Clock, selects, enable carry bits 4,5,6,2,3,7
// - Master-out to bits 8-11, master-in 12-15
`timescale 1ns/100ps
`default_nettype none
module stpmx_pin_mux
  import stpmx_pkg::*;
#(
  parameter int unsigned CS_W   = STPMX_CS_W,
  parameter int unsigned LANE_W = STPMX_LANE_W
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_arst_n,
  // Unit enables, same clock domain
  input  wire logic                    i_port_five_en,
  input  wire logic                    i_datamod_en,
  // Serial port five, unit side
  input  wire logic                    i_port_five_serial_clock_out,
  input  wire logic                    i_port_five_serial_clock_oe_n,
  output var  logic                    o_port_five_serial_clock_in,
  input  wire logic [CS_W-1:0]         i_port_five_chip_select_out,
  input  wire logic [CS_W-1:0]         i_port_five_chip_select_oe_n,
  output var  logic [CS_W-1:0]         o_port_five_chip_select_in,
  input  wire logic                    i_port_five_enable_pin_out,
  input  wire logic                    i_port_five_enable_pin_oe_n,
  output var  logic                    o_port_five_enable_pin_in,
  input  wire logic [LANE_W-1:0]       i_port_five_master_out_out,
  input  wire logic [LANE_W-1:0]       i_port_five_master_out_oe_n,
  output var  logic [LANE_W-1:0]       o_port_five_master_out_in,
  input  wire logic [LANE_W-1:0]       i_port_five_master_in_out,
  input  wire logic [LANE_W-1:0]       i_port_five_master_in_oe_n,
  output var  logic [LANE_W-1:0]       o_port_five_master_in_in,
  // Datamod unit side
  input  wire logic [STPMX_DATA_W-1:0] i_datamod_data_bus,
  input  wire logic                    i_datamod_clock,
  input  wire logic                    i_datamod_sync,
  input  wire logic                    i_datamod_enable,
  // Dedicated datamod pads
  output var  logic                    o_datamod_clock_pin,
  output var  logic                    o_datamod_sync_pin,
  output var  logic                    o_datamod_enable_pin,
  output var  logic [STPMX_DED_DATA_W-1:0] o_datamod_data_pin,
  // Shared pads, pin order: clk, cs0..3, ena, mo0..3, mi0..3
  input  wire logic [STPMX_SHARED_W-1:0]   i_shared_pad,
  output var  logic [STPMX_SHARED_W-1:0]   o_shared_pad,
  output var  logic [STPMX_SHARED_W-1:0]   o_shared_pad_oe_n,
  output var  logic [1:0]                  o_pin_owner
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_meta_next;
  logic rst_sync_next;
  always_comb begin
    rst_meta_next = 1'h1;
    rst_sync_next = rst_meta_reg;
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= STPMX_RST_LEVEL;
      rst_sync_reg <= STPMX_RST_LEVEL;
    end else begin
      rst_meta_reg <= rst_meta_next;
      rst_sync_reg <= rst_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ownership
  stpmx_sel_if sel_if ();
  // Held off during reset so pads stay released
  assign sel_if.port_en    = i_port_five_en & rst_sync_reg;
  assign sel_if.datamod_en = i_datamod_en & rst_sync_reg;
  stpmx_sel u_sel (
    .sel (sel_if.dec)
  );
  assign o_pin_owner = sel_if.owner;

  ////////////////////////////////////////////////////////////////////////////
  // Pad muxing, combinational so ownership follows enables at once
  logic [STPMX_SHARED_W-1:0] port_out;
  logic [STPMX_SHARED_W-1:0] port_oe_n;
  logic [STPMX_SHARED_W-1:0] dm_out;
  logic [CS_W-1:0]           dm_cs;
  logic [LANE_W-1:0]         dm_mo;
  logic [LANE_W-1:0]         dm_mi;

  function automatic logic [STPMX_SHARED_W-1:0] pack_pins(
    input logic              clk,
    input logic [CS_W-1:0]   cs,
    input logic              ena,
    input logic [LANE_W-1:0] mo,
    input logic [LANE_W-1:0] mi
  );
    pack_pins = {mi, mo, ena, cs, clk};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial port side, packed in pad order
  always_comb begin
    port_out  = pack_pins(
      i_port_five_serial_clock_out,
      i_port_five_chip_select_out,
      i_port_five_enable_pin_out,
      i_port_five_master_out_out,
      i_port_five_master_in_out
    );
    port_oe_n = pack_pins(
      i_port_five_serial_clock_oe_n,
      i_port_five_chip_select_oe_n,
      i_port_five_enable_pin_oe_n,
      i_port_five_master_out_oe_n,
      i_port_five_master_in_oe_n
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datamod side: selects are scrambled, lanes run in order
  // Select mapping is fixed at four; a wider select group gets no datamod bits
  always_comb begin
    dm_cs    = '0;
    dm_cs[0] = i_datamod_data_bus[STPMX_BIT_CS0];
    dm_cs[1] = i_datamod_data_bus[STPMX_BIT_CS1];
    dm_cs[2] = i_datamod_data_bus[STPMX_BIT_CS2];
    dm_cs[3] = i_datamod_data_bus[STPMX_BIT_CS3];
  end

  for (genvar g = 0; g < LANE_W; g++) begin : g_lane
    assign dm_mo[g] = i_datamod_data_bus[STPMX_BIT_MO0 + g];
    assign dm_mi[g] = i_datamod_data_bus[STPMX_BIT_MI0 + g];
  end

  always_comb begin
    dm_out = pack_pins(
      i_datamod_data_bus[STPMX_BIT_CLK],
      dm_cs,
      i_datamod_data_bus[STPMX_BIT_ENA],
      dm_mo,
      dm_mi
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive by owner

  always_comb begin
    unique case (sel_if.owner)
      STPMX_OWN_PORT: begin
        o_shared_pad      = port_out;
        o_shared_pad_oe_n = port_oe_n;
      end
      STPMX_OWN_DATAMOD: begin
        o_shared_pad      = dm_out;
        o_shared_pad_oe_n = '0;
      end
      default: begin
        // Nobody owns the pads: release them
        o_shared_pad      = '0;
        o_shared_pad_oe_n = '1;
      end
    endcase
  end

  // Pad inputs reach the port only while it owns them; the port's own
  // receive path resynchronises, so no extra stages here
  ////////////////////////////////////////////////////////////////////////////
  // Pad receive path
  always_comb begin
    logic [STPMX_SHARED_W-1:0] rx;
    rx = (sel_if.owner == STPMX_OWN_PORT) ? i_shared_pad : '0;
    o_port_five_serial_clock_in = rx[0];
    o_port_five_chip_select_in  = rx[CS_W:1];
    o_port_five_enable_pin_in   = rx[CS_W+1];
    o_port_five_master_out_in   = rx[CS_W+1+LANE_W:CS_W+2];
    o_port_five_master_in_in    = rx[STPMX_SHARED_W-1:CS_W+2+LANE_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dedicated datamod pins, never muxed
  always_comb begin
    o_datamod_clock_pin  = i_datamod_clock;
    o_datamod_sync_pin   = i_datamod_sync;
    o_datamod_enable_pin = i_datamod_enable;
    o_datamod_data_pin   = i_datamod_data_bus[STPMX_DED_DATA_W-1:0];
  end
endmodule
`default_nettype wire

// *** verification/stpmx_pin_mux_asserts.sv ***
// Checker: pin ownership and mapping assertions
`timescale 1ns/100ps
`default_nettype none
module stpmx_pin_mux_asserts
  import stpmx_pkg::*;
(
  input wire logic        i_sys_clk, i_arst_n, i_port_five_en, i_datamod_en,
  input wire logic [3:0]  i_port_five_chip_select_out, i_port_five_master_in_oe_n,
  input wire logic [3:0]  o_port_five_master_in_in,
  input wire logic [15:0] i_datamod_data_bus,
  input wire logic        i_datamod_clock, o_datamod_clock_pin,
  input wire logic [1:0]  o_datamod_data_pin, o_pin_owner,
  input wire logic [13:0] i_shared_pad, o_shared_pad, o_shared_pad_oe_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  // Reset release takes two edges to reach the decoder, so count from release
  sequence s_dm_held; (i_arst_n && i_datamod_en && !i_port_five_en) [*3]; endsequence
  property p_port_own; (i_arst_n && i_port_five_en) [*3] |-> o_pin_owner == 2'h1; endproperty
  a_port_own: assert property (p_port_own) else $error("port not owner");
  property p_port_cs; o_pin_owner == 2'h1 |-> o_shared_pad[4:1] == i_port_five_chip_select_out;
  endproperty
  a_port_cs: assert property (p_port_cs) else $error("select pads wrong");
  property p_port_mi; o_pin_owner == 2'h1 |-> o_shared_pad_oe_n[13:10] == i_port_five_master_in_oe_n
    && o_port_five_master_in_in == i_shared_pad[13:10]; endproperty
  a_port_mi: assert property (p_port_mi) else $error("master-in pads wrong");
  property p_dm_own; s_dm_held |-> o_pin_owner == 2'h2 && o_shared_pad_oe_n == 14'h0; endproperty
  a_dm_own: assert property (p_dm_own) else $error("datamod not owner");
  property p_none; !i_port_five_en && !i_datamod_en |-> o_shared_pad_oe_n == 14'h3fff; endproperty
  a_none: assert property (p_none) else $error("pads not released");
  property p_ded; o_datamod_clock_pin == i_datamod_clock
    && o_datamod_data_pin == i_datamod_data_bus[1:0]; endproperty
  a_ded: assert property (p_ded) else $error("dedicated pins wrong");
  property p_map; o_pin_owner == 2'h2 |-> o_shared_pad == {i_datamod_data_bus[15:7],
    i_datamod_data_bus[3:2], i_datamod_data_bus[6:4]}; endproperty
  a_map: assert property (p_map) else $error("datamod mapping wrong");
  property p_switch; $rose(i_port_five_en) && $past(o_pin_owner) == 2'h2 |-> o_pin_owner == 2'h1;
  endproperty
  a_switch: assert property (p_switch) else $error("owner late");
endmodule
bind stpmx_pin_mux stpmx_pin_mux_asserts u_chk (.*);
`default_nettype wire

// *** verification/stpmx_far_model.sv ***
// Partner: both units' outputs and external pad level
`timescale 1ns/100ps
`default_nettype none
module stpmx_far_model (
  input  wire logic        i_sys_clk,
  output var  logic [63:0] o_pat
);
  logic [63:0] seq_reg = 64'h0123456789abcdef;
  // New value every cycle, so released pads never hold the last level
  always @(posedge i_sys_clk) seq_reg <= seq_reg * 64'h5851f42d4c957f2d + 64'h14057b7ef767814f;
  assign o_pat = seq_reg ^ (seq_reg >> 29);
endmodule
`default_nettype wire

// *** verification/tb_serial_trace_shared_pin_mux.sv ***
// Testbench: ownership, mapping and reset of the shared pin mux
`timescale 1ns/100ps
`default_nettype none
module tb_serial_trace_shared_pin_mux;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_port_five_en = 1'b0, i_datamod_en = 1'b0;
  logic i_port_five_serial_clock_out, i_port_five_serial_clock_oe_n, o_port_five_serial_clock_in;
  logic i_port_five_enable_pin_out, i_port_five_enable_pin_oe_n, o_port_five_enable_pin_in;
  logic [3:0] i_port_five_chip_select_out, i_port_five_chip_select_oe_n;
  logic [3:0] i_port_five_master_out_out, i_port_five_master_out_oe_n, o_port_five_master_out_in;
  logic [3:0] i_port_five_master_in_out, i_port_five_master_in_oe_n, o_port_five_master_in_in;
  logic [3:0] o_port_five_chip_select_in;
  logic [15:0] i_datamod_data_bus;
  logic i_datamod_clock, i_datamod_sync, i_datamod_enable;
  logic o_datamod_clock_pin, o_datamod_sync_pin, o_datamod_enable_pin;
  logic [1:0] o_datamod_data_pin, o_pin_owner;
  logic [13:0] i_shared_pad, o_shared_pad, o_shared_pad_oe_n;
  logic [63:0] pat;
  int bad_count = 0;
  int n_tests = 0;
  wire [15:0] dm = pat[43:28];
  wire [13:0] pin_in = {o_port_five_master_in_in, o_port_five_master_out_in,
    o_port_five_enable_pin_in, o_port_five_chip_select_in, o_port_five_serial_clock_in};
  ////////////////////////////////////////
  stpmx_far_model u_far (.i_sys_clk(i_sys_clk), .o_pat(pat));
  stpmx_pin_mux uut (.*);
  assign {i_port_five_master_in_out, i_port_five_master_out_out, i_port_five_enable_pin_out,
    i_port_five_chip_select_out, i_port_five_serial_clock_out} = pat[13:0];
  assign {i_port_five_master_in_oe_n, i_port_five_master_out_oe_n, i_port_five_enable_pin_oe_n,
    i_port_five_chip_select_oe_n, i_port_five_serial_clock_oe_n} = pat[27:14];
  assign i_datamod_data_bus = dm;
  assign {i_datamod_clock, i_datamod_sync, i_datamod_enable} = pat[46:44];
  // Pad level: ours where driven, an outside level where released
  assign i_shared_pad = (o_shared_pad & ~o_shared_pad_oe_n) | (pat[60:47] & o_shared_pad_oe_n);
  always #20 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Enters and leaves 1 ns after an edge; checks within the same cycle
  task automatic cyc(input logic p, input logic d);
    #4;
    chk("owner", o_pin_owner, p ? 2'h1 : {d, 1'b0});
    chk("pad", o_shared_pad, p ? pat[13:0] : d ? {dm[15:7], dm[3:2], dm[6:4]} : 14'h0);
    chk("oe_n", o_shared_pad_oe_n, p ? pat[27:14] : {14{!d}});
    chk("in", pin_in, p ? i_shared_pad : 14'h0);
    chk("ded", {o_datamod_clock_pin, o_datamod_sync_pin, o_datamod_enable_pin,
      o_datamod_data_pin}, {pat[46:44], dm[1:0]});
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic t_modes;
    for (int k = 0; k < 4; k++) begin
      {i_port_five_en, i_datamod_en} = k[1:0];
      repeat (3) cyc(k[1], k[0]);
    end
  endtask
  task automatic t_switch;
    i_datamod_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      i_port_five_en = k[0];
      cyc(k[0], 1'b1);
    end
  endtask
  task automatic t_reset;
    i_arst_n = 1'b0;
    repeat (2) cyc(1'b0, 1'b0);
    i_arst_n = 1'b1;
    repeat (2) cyc(1'b0, 1'b0);
    cyc(1'b1, 1'b1);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    #1 i_arst_n = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    t_modes();
    t_switch();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
